// *** hdl/sei_eeprom_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Reset input returns everything to standby.
// - Ready for commands after power-up delay.
// - Sample on SCL rise, drive on fall.
// - Write-inhibit high blocks all writes.
// - Select pins default low when undriven.
// - Zero pulls SDA low, one releases.
// - SDA change while SCL high is framing.
// - START is SDA fall, SCL high.
// - STOP launches write or returns standby.
// - Match preamble 1010 and select pins.
// - Last address bit selects read/write.
// - Ack address, word address, write data.
// - Read: shift byte, release, continue on ack.
// - Byte write acks three bytes, STOP writes.
// - No ack while internal write busy.
// - Sample inhibit before data; refuse byte.
// - Upper four address bits select page.
module sei_eeprom_slave
   import sei_pkg::*;
#(
   parameter int POWER_UP_CYC = POWER_UP_CYCLES,
   parameter int WRITE_CYC = WRITE_CYCLES
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic SELECT_PIN_0,
   input wire logic SELECT_PIN_1,
   input wire logic SELECT_PIN_2,
   input wire logic WRITE_INHIBIT,
   output logic READY,
   output logic WRITE_BUSY
);
   // ------------------------------------------------------------
   // Core domain: power-up and internal write timers
   // ------------------------------------------------------------
   // The bus side runs on SCL itself, so at 400 kHz the core clock
   // is far faster and every crossing has ample margin.
   logic [TIMER_W-1:0] pu_cnt_reg, pu_cnt_next;
   logic [TIMER_W-1:0] wr_cnt_reg, wr_cnt_next;
   logic ready_reg, ready_next;
   logic busy_reg, busy_next;
   logic start_wr;
   logic wr_tog;
   logic [7:0] mem [MEM_DEPTH];
   logic [7:0] commit_addr;
   logic [7:0] commit_data;

   sei_toggle_sync u_wr_evt (
      .clk(CORE_CLK),
      .rst(RST),
      .toggle_in(wr_tog),
      .pulse(start_wr)
   );

   always_comb begin
      pu_cnt_next = pu_cnt_reg;
      ready_next = ready_reg;
      wr_cnt_next = wr_cnt_reg;
      busy_next = busy_reg;
      if (!ready_reg) begin
         if (pu_cnt_reg == TIMER_W'(POWER_UP_CYC - 1)) begin
            ready_next = 1'b1;
         end else begin
            pu_cnt_next = pu_cnt_reg + 1'b1;
         end
      end
      if (start_wr) begin
         busy_next = 1'b1;
         wr_cnt_next = '0;
      end else if (busy_reg) begin
         if (wr_cnt_reg == TIMER_W'(WRITE_CYC - 1)) begin
            busy_next = 1'b0;
         end else begin
            wr_cnt_next = wr_cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pu_cnt_reg <= '0;
         ready_reg <= 1'b0;
         wr_cnt_reg <= '0;
         busy_reg <= 1'b0;
      end else begin
         pu_cnt_reg <= pu_cnt_next;
         ready_reg <= ready_next;
         wr_cnt_reg <= wr_cnt_next;
         busy_reg <= busy_next;
      end
   end

   // Array commits once per write; address and data are frozen in
   // the link domain until the next STOP, which cannot come before
   // the toggle has crossed.
   // Reset stands in for the erased delivery state of the array.
   // This model therefore loses its contents on every reset.
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] <= ERASED_BYTE;
         end
      end else if (start_wr) begin
         mem[commit_addr] <= commit_data;
      end
   end

   assign READY = ready_reg;
   assign WRITE_BUSY = busy_reg;

   // ------------------------------------------------------------
   // Core to link levels
   // ------------------------------------------------------------
   logic link_ready;
   logic link_busy;
   logic link_rst;

   sei_sync2 u_rdy (
      .clk(SCL),
      .rst(RST),
      .din(ready_reg & ~busy_reg),
      .dout(link_ready)
   );
   // Reset, and the wait before READY, clear the link logic at once, without waiting for SCL.
   assign link_rst = RST | ~ready_reg;
   assign link_busy = ~link_ready;

   // ------------------------------------------------------------
   // Link domain: START and STOP detection
   // ------------------------------------------------------------
   // START/STOP are edges of SDA while SCL is high; SDA serves as
   // the clock for these flags, and the SCL side clears them by a
   // toggle compare so no flag has two drivers.
   logic start_tog_reg, stop_tog_reg;
   logic start_seen_reg, stop_seen_reg;

   always_ff @(negedge SDA_IN or posedge link_rst) begin
      if (link_rst) begin
         start_tog_reg <= 1'b0;
      end else if (SCL) begin
         start_tog_reg <= ~start_tog_reg;
      end
   end

   always_ff @(posedge SDA_IN or posedge link_rst) begin
      if (link_rst) begin
         stop_tog_reg <= 1'b0;
      end else if (SCL) begin
         stop_tog_reg <= ~stop_tog_reg;
      end
   end

   // ------------------------------------------------------------
   // Link domain: byte engine on SCL rising edge
   // ------------------------------------------------------------
   sei_link_state_t st_reg, st_next;
   logic [3:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next;
   logic [7:0] addr_reg, addr_next;
   logic [7:0] data_reg, data_next;
   logic ack_reg, ack_next;
   logic mack_reg, mack_next;
   logic wr_pend_reg, wr_pend_next;
   logic wr_launch_reg;
   logic inhibit_reg;
   logic [2:0] sel;
   logic is_start, is_stop;

   // Undriven select and inhibit pins are pulled low at the pad.
   assign sel = {SELECT_PIN_2, SELECT_PIN_1, SELECT_PIN_0};
   assign is_start = start_tog_reg != start_seen_reg;
   assign is_stop = stop_tog_reg != stop_seen_reg;
   assign wr_tog = wr_launch_reg;
   assign commit_addr = addr_reg;
   assign commit_data = data_reg;

   // STOP itself launches the write: SCL stands still after it, so
   // no rising edge would come to carry the request.
   always_ff @(posedge SDA_IN or posedge link_rst) begin
      if (link_rst) begin
         wr_launch_reg <= 1'b0;
      end else if (SCL && wr_pend_reg) begin
         wr_launch_reg <= ~wr_launch_reg;
      end
   end

   always_comb begin
      st_next = st_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      ack_next = ack_reg;
      mack_next = mack_reg;
      wr_pend_next = wr_pend_reg;
      if (is_stop) begin
         wr_pend_next = 1'b0;
         st_next = SEI_IDLE;
         bit_next = '0;
      end
      if (is_start) begin
         st_next = SEI_DEV_ADDR;
         // The first address bit rides on the edge that sees START.
         bit_next = 4'h1;
         sh_next = {sh_reg[6:0], SDA_IN};
         wr_pend_next = 1'b0;
         ack_next = 1'b0;
      end
      if (!is_start && !is_stop && st_reg != SEI_IDLE &&
          st_reg != SEI_IGNORE) begin
         bit_next = (bit_reg == ACK_BIT_IDX) ? 4'h0 : bit_reg + 4'h1;
         if (bit_reg != ACK_BIT_IDX) begin
            sh_next = {sh_reg[6:0], SDA_IN};
         end
         unique case (st_reg)
            SEI_DEV_ADDR: begin
               if (bit_reg == LAST_BIT_IDX) begin
                  // Address match, and silence while writing.
                  ack_next = (sh_reg[6:3] == MEM_PREAMBLE) &&
                     (sh_reg[2:0] == sel) && !link_busy;
               end else if (bit_reg == ACK_BIT_IDX) begin
                  if (!ack_reg) begin
                     st_next = SEI_IGNORE;
                  end else if (sh_reg[0]) begin
                     st_next = SEI_RD_DATA;
                     mack_next = 1'b1;
                  end else begin
                     st_next = SEI_WORD_ADDR;
                  end
                  ack_next = 1'b0;
               end
            end
            SEI_WORD_ADDR: begin
               if (bit_reg == LAST_BIT_IDX) begin
                  ack_next = 1'b1;
               end else if (bit_reg == ACK_BIT_IDX) begin
                  // Upper nibble is the page, lower the byte.
                  addr_next = {sh_reg[PAGE_MSB:PAGE_LSB],
                     sh_reg[BYTE_IN_PAGE_MSB:0]};
                  st_next = SEI_WR_DATA;
                  ack_next = 1'b0;
               end
            end
            SEI_WR_DATA: begin
               if (bit_reg == LAST_BIT_IDX) begin
                  ack_next = !inhibit_reg;
               end else if (bit_reg == ACK_BIT_IDX) begin
                  if (ack_reg) begin
                     data_next = sh_reg;
                     wr_pend_next = 1'b1;
                  end else begin
                     st_next = SEI_IGNORE;
                  end
                  ack_next = 1'b0;
               end
            end
            SEI_RD_DATA: begin
               if (bit_reg == ACK_BIT_IDX) begin
                  mack_next = !SDA_IN;
                  if (SDA_IN) begin
                     st_next = SEI_IGNORE;
                  end else begin
                     addr_next = addr_reg + 8'h01;
                  end
               end
            end
            default: begin
               st_next = SEI_IGNORE;
            end
         endcase
      end
   end

   always_ff @(posedge SCL or posedge link_rst) begin
      if (link_rst) begin
         st_reg <= SEI_IDLE;
         bit_reg <= '0;
         sh_reg <= '0;
         addr_reg <= '0;
         data_reg <= '0;
         ack_reg <= 1'b0;
         mack_reg <= 1'b0;
         wr_pend_reg <= 1'b0;
         start_seen_reg <= 1'b0;
         stop_seen_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         ack_reg <= ack_next;
         mack_reg <= mack_next;
         wr_pend_reg <= wr_pend_next;
         start_seen_reg <= start_tog_reg;
         stop_seen_reg <= stop_tog_reg;
      end
   end

   // ------------------------------------------------------------
   // Link domain: SDA driver on SCL falling edge
   // ------------------------------------------------------------
   // The inhibit pin is caught on the falling edge just before the
   // first data bit arrives, which is the one the data byte uses.
   logic oe_reg, oe_next;
   logic inh_next;
   logic [7:0] rd_byte;

   assign rd_byte = mem[addr_reg];

   always_comb begin
      oe_next = 1'b0;
      inh_next = inhibit_reg;
      if (st_reg == SEI_WR_DATA && bit_reg == 4'h0) begin
         inh_next = WRITE_INHIBIT;
      end
      if (bit_reg == ACK_BIT_IDX) begin
         oe_next = ack_reg;
      end else if (st_reg == SEI_RD_DATA && mack_reg) begin
         // Open drain: drive only for a zero bit.
         oe_next = !rd_byte[3'(LAST_BIT_IDX - bit_reg)];
      end
   end

   always_ff @(negedge SCL or posedge link_rst) begin
      if (link_rst) begin
         oe_reg <= 1'b0;
         inhibit_reg <= 1'b0;
      end else begin
         oe_reg <= oe_next;
         inhibit_reg <= inh_next;
      end
   end

   assign SDA_OUT = 1'b0;
   assign SDA_OE = oe_reg;
endmodule : sei_eeprom_slave
`default_nettype wire

// *** hdl/sei_pkg.sv ***
package sei_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CORE_CLK_MHZ = 250;
   localparam int POWER_UP_READY_DELAY_US = 1000;
   localparam int INTERNAL_WRITE_TIME_US = 5000;
   localparam int POWER_UP_CYCLES = POWER_UP_READY_DELAY_US * CORE_CLK_MHZ;
   localparam int WRITE_CYCLES = INTERNAL_WRITE_TIME_US * CORE_CLK_MHZ;
   localparam int TIMER_W = 24;
   // ------------------------------------------------------------
   // Addressing
   // ------------------------------------------------------------
   localparam logic [3:0] MEM_PREAMBLE = 4'ha;
   localparam int PAGE_MSB = 7;
   localparam int PAGE_LSB = 4;
   localparam int BYTE_IN_PAGE_MSB = 3;
   localparam int MEM_DEPTH = 256;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [3:0] LAST_BIT_IDX = 4'h7;
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;
   // ------------------------------------------------------------
   // Link states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SEI_IDLE, SEI_DEV_ADDR, SEI_WORD_ADDR, SEI_WR_DATA, SEI_RD_DATA,
      SEI_IGNORE
   } sei_link_state_t;
endpackage : sei_pkg

// *** hdl/sei_sync2.sv ***
`timescale 1ns/100ps
`default_nettype none
module sei_sync2
   import sei_pkg::*;
#(
   parameter logic INIT = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic meta_reg;
   logic meta_next;
   logic out_reg;
   logic out_next;

   always_comb begin
      meta_next = din;
      out_next = meta_reg;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= INIT;
         out_reg <= INIT;
      end else begin
         meta_reg <= meta_next;
         out_reg <= out_next;
      end
   end

   assign dout = out_reg;
endmodule : sei_sync2
`default_nettype wire

// *** hdl/sei_toggle_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module sei_toggle_sync
   import sei_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic toggle_in,
   output logic pulse
);
   logic tog_sync;
   logic last_reg;
   logic last_next;

   sei_sync2 u_sync (
      .clk(clk),
      .rst(rst),
      .din(toggle_in),
      .dout(tog_sync)
   );

   always_comb begin
      last_next = tog_sync;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         last_reg <= 1'b0;
      end else begin
         last_reg <= last_next;
      end
   end

   assign pulse = tog_sync ^ last_reg;
endmodule : sei_toggle_sync
`default_nettype wire

// *** sim/sei_chk_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module sei_chk
   import sei_pkg::*;
#(
   parameter int POWER_UP_CYC = 20,
   parameter int WRITE_CYC = 40
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic SCL,
   input wire logic SDA_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic READY,
   input wire logic WRITE_BUSY
);
   int rdy_reg, rdy_next, busy_reg, busy_next, stop_reg, stop_next;
   logic scl_reg, sda_reg;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   // The stop age saturates so that long idle spells never wrap.
   always_comb begin
      rdy_next = READY ? rdy_reg : rdy_reg + 1;
      busy_next = WRITE_BUSY ? busy_reg + 1 : 0;
      stop_next = (stop_reg < 99) ? stop_reg + 1 : stop_reg;
      if (SCL && scl_reg && SDA_IN && !sda_reg) begin
         stop_next = 0;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      scl_reg <= SCL;
      sda_reg <= SDA_IN;
      if (RST) begin
         rdy_reg <= 0;
         busy_reg <= 0;
         stop_reg <= 99;
      end else begin
         rdy_reg <= rdy_next;
         busy_reg <= busy_next;
         stop_reg <= stop_next;
      end
   end
   a_reset_quiet: assert property ($fell(RST) |->
      !READY && !WRITE_BUSY && !SDA_OE) else $error("outputs up in reset");
   a_ready_delay: assert property (!READY |->
      rdy_reg <= POWER_UP_CYC + 4) else $error("ready too late");
   a_ready_hold: assert property (READY |=> READY)
      else $error("ready dropped");
   a_sda_edge: assert property ($changed(SDA_OE) |-> !SCL)
      else $error("data moved with clock high");
   a_sda_low: assert property (SDA_OE |-> !SDA_OUT)
      else $error("data driven high");
   a_busy_quiet: assert property (WRITE_BUSY |-> !SDA_OE)
      else $error("answered while busy");
   a_idle_quiet: assert property (!READY |-> !SDA_OE)
      else $error("answered before ready");
   a_busy_len: assert property ($fell(WRITE_BUSY) |->
      busy_reg >= WRITE_CYC - 2 && busy_reg <= WRITE_CYC + 2)
      else $error("write time wrong");
   a_busy_cause: assert property ($rose(WRITE_BUSY) |-> stop_reg <= 10)
      else $error("write began without stop");
endmodule : sei_chk
bind sei_eeprom_slave sei_chk #(
   .POWER_UP_CYC(POWER_UP_CYC),
   .WRITE_CYC(WRITE_CYC)
) chk_u (
   .CORE_CLK(CORE_CLK), .RST(RST), .SCL(SCL), .SDA_IN(SDA_IN),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .READY(READY),
   .WRITE_BUSY(WRITE_BUSY)
);
`default_nettype wire

// *** sim/sei_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module sei_master (
   output logic scl,
   output logic pull,
   input wire logic sda
);
   // The clock stands high between frames; only this side drives it.
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic start();
      if (!scl) begin
         pull = 1'b0;
         #16 scl = 1'b1;
         #16;
      end
      pull = 1'b1;
      #16 scl = 1'b0;
   endtask : start
   task automatic stop();
      #16 pull = 1'b1;
      #16 scl = 1'b1;
      #16 pull = 1'b0;
      #80;
   endtask : stop
   task automatic bit_io(input logic b, output logic r);
      #16 pull = !b;
      #16 scl = 1'b1;
      #16 r = sda;
      #16 scl = 1'b0;
   endtask : bit_io
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask : wr
   task automatic rd(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(!mack, r);
   endtask : rd
endmodule : sei_master
`default_nettype wire

// *** sim/tb_sei_eeprom_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
   $display("ERROR %0t: got %h want %h", $time, a, e); end end
module tb_sei_eeprom_slave;
   import sei_pkg::*;
   logic CORE_CLK = 1'b0, RST = 1'b1, WRITE_INHIBIT = 1'b0;
   logic [2:0] sel = 3'h5;
   logic SDA_OUT, SDA_OE, READY, WRITE_BUSY, SCL, pull, ack, a1, a2;
   logic [7:0] rd, dw;
   wire logic sda;
   int failures = 0, cmp_count = 0;
   assign sda = !(pull || (SDA_OE && !SDA_OUT));
   assign dw = {4'ha, sel, 1'b0};
   always #2 CORE_CLK = ~CORE_CLK;
   sei_eeprom_slave #(.POWER_UP_CYC(20), .WRITE_CYC(400)) dut_u (
      .CORE_CLK(CORE_CLK), .RST(RST), .SCL(SCL), .SDA_IN(sda),
      .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SELECT_PIN_0(sel[0]),
      .SELECT_PIN_1(sel[1]), .SELECT_PIN_2(sel[2]),
      .WRITE_INHIBIT(WRITE_INHIBIT), .READY(READY),
      .WRITE_BUSY(WRITE_BUSY));
   sei_master m_u (.scl(SCL), .pull(pull), .sda(sda));
   task results();
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   task wait_busy(input logic v);
      int i;
      for (i = 0; i < 2000 && WRITE_BUSY !== v; i++) @(negedge CORE_CLK);
      if (i == 2000) begin
         failures++;
         $display("ERROR %0t: busy wait timed out", $time);
         results();
      end
   endtask : wait_busy
   task t_reset();
      int i;
      @(negedge CORE_CLK) RST = 1'b1;
      repeat (3) @(negedge CORE_CLK);
      `CHK({READY, WRITE_BUSY, SDA_OE}, 3'h0)
      RST = 1'b0;
      for (i = 0; i < 60 && READY !== 1'b1; i++) @(negedge CORE_CLK);
      `CHK(i >= 18 && i <= 24, 1'b1)
      #300;
      $display("t_reset done");
   endtask : t_reset
   task t_addr();
      for (int k = 0; k < 8; k++) begin
         m_u.start();
         m_u.wr({4'ha, k[2:0], 1'b0}, ack);
         m_u.stop();
         `CHK(ack, k == 5)
      end
      m_u.start();
      m_u.wr({4'h6, sel, 1'b0}, ack);
      m_u.stop();
      `CHK(ack, 1'b0)
      @(negedge CORE_CLK) sel = 3'h0;
      m_u.start();
      m_u.wr(8'ha0, ack);
      m_u.stop();
      `CHK(ack, 1'b1)
      @(negedge CORE_CLK) sel = 3'h5;
      $display("t_addr done");
   endtask : t_addr
   task t_write();
      m_u.start();
      m_u.wr(dw, ack);
      m_u.wr(8'h10, a1);
      m_u.wr(8'h5a, a2);
      m_u.stop();
      `CHK({ack, a1, a2}, 3'h7)
      wait_busy(1'b1);
      m_u.start();
      m_u.wr(dw, ack);
      m_u.stop();
      `CHK(ack, 1'b0)
      wait_busy(1'b0);
      m_u.start();
      m_u.wr(dw, ack);
      m_u.stop();
      `CHK(ack, 1'b1)
      $display("t_write done");
   endtask : t_write
   task t_read(input logic [7:0] wa, input logic [7:0] d0, input logic two);
      m_u.start();
      m_u.wr(dw, ack);
      m_u.wr(wa, a1);
      m_u.start();
      m_u.wr(dw | 8'h01, a2);
      `CHK({ack, a1, a2}, 3'h7)
      m_u.rd(two, rd);
      `CHK(rd, d0)
      if (two) begin
         m_u.rd(1'b0, rd);
         `CHK(rd, ERASED_BYTE)
      end
      m_u.stop();
      repeat (20) @(negedge CORE_CLK);
      `CHK(WRITE_BUSY, 1'b0)
      $display("t_read done");
   endtask : t_read
   task t_inhibit();
      @(negedge CORE_CLK) WRITE_INHIBIT = 1'b1;
      m_u.start();
      m_u.wr(dw, ack);
      m_u.wr(8'h20, a1);
      m_u.wr(8'h33, a2);
      m_u.stop();
      `CHK({ack, a1, a2}, 3'h6)
      repeat (20) @(negedge CORE_CLK);
      `CHK(WRITE_BUSY, 1'b0)
      WRITE_INHIBIT = 1'b0;
      t_read(8'h20, ERASED_BYTE, 1'b0);
      $display("t_inhibit done");
   endtask : t_inhibit
   initial begin
      t_reset();
      t_addr();
      t_write();
      t_read(8'h10, 8'h5a, 1'b1);
      t_inhibit();
      t_reset();
      results();
   end
endmodule : tb_sei_eeprom_slave
`default_nettype wire
